// >>> verilog/alt_func_pkg.sv
package alt_func_pkg;

  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int          DATA_W     = 32;
  localparam int          ADDR_W     = 8;
  localparam int          REG_COUNT  = 7;
  localparam int          IDX_W      = 3;
  localparam logic [3:0]  FULL_STROBE = 4'hF;
  localparam logic [1:0]  WORD_ALIGN  = 2'h0;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_EVENT_ROUTE     = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_REMAP_ONE       = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_INT_SEL_ONE     = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_INT_SEL_TWO     = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_INT_SEL_THREE   = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_INT_SEL_FOUR    = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_REMAP_TWO       = 8'h18;
  localparam logic [IDX_W-1:0]  IDX_EVENT_ROUTE     = OFS_EVENT_ROUTE[IDX_W+1:2];
  localparam logic [IDX_W-1:0]  IDX_REMAP_ONE       = OFS_REMAP_ONE[IDX_W+1:2];

  // ----------------------------------------------------------------
  // Reset values and writable masks
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] RESET_VALUE       = 32'h0000_0000;
  localparam logic [DATA_W-1:0] EVENT_ROUTE_MASK  = 32'h0000_00FF;
  localparam logic [DATA_W-1:0] REMAP_ONE_MASK    = 32'h0000_1FFF;
  localparam logic [DATA_W-1:0] FULL_MASK         = 32'hFFFF_FFFF;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int EV_PIN_LSB  = 0;
  localparam int EV_PORT_LSB = 4;
  localparam int EV_EN_BIT   = 7;
  localparam int REMAP_ONE_W = 13;
  localparam int SPI_MV_BIT  = 0;
  localparam int I2C_MV_BIT  = 1;
  localparam int SER1_MV_BIT = 2;
  localparam int SER2_MV_BIT = 3;
  localparam int SER3_MV_LSB = 4;
  localparam int TMR1_MV_LSB = 6;
  localparam int TMR2_MV_LSB = 8;
  localparam int TMR3_MV_LSB = 10;
  localparam int TMR4_MV_BIT = 12;

  // ----------------------------------------------------------------
  // Ports and pin indices
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    PORT_A = 3'h0,
    PORT_B = 3'h1,
    PORT_C = 3'h2,
    PORT_D = 3'h3,
    PORT_E = 3'h4
  } port_t;
  localparam int PIN_PER_PORT = 16;
  localparam int PIN_TOTAL    = 80;
  typedef logic [6:0] pin_idx_t;

  // Signal slots in the pin map, base of each peripheral
  localparam int SIG_SPI   = 0;
  localparam int SIG_I2C   = 4;
  localparam int SIG_SER1  = 6;
  localparam int SIG_SER2  = 8;
  localparam int SIG_SER3  = 13;
  localparam int SIG_TMR1  = 18;
  localparam int SIG_TMR2  = 27;
  localparam int SIG_TMR3  = 31;
  localparam int SIG_TMR4  = 36;
  localparam int SIG_COUNT = 41;

  // Pin index is port in the upper bits, pin number below
  function automatic pin_idx_t pin_at(port_t p, logic [3:0] n);
    return {p, n};
  endfunction

  // Writable bits of each register, by word index
  function automatic logic [DATA_W-1:0] reg_mask(logic [IDX_W-1:0] i);
    if (i == IDX_EVENT_ROUTE)
      return EVENT_ROUTE_MASK;
    if (i == IDX_REMAP_ONE)
      return REMAP_ONE_MASK;
    return FULL_MASK;
  endfunction

endpackage

// >>> verilog/route_cfg_if.sv
`timescale 1ns/1ps
interface route_cfg_if;
  import alt_func_pkg::*;

  logic [3:0]             event_pin_number;     // Pin within port
  logic [2:0]             event_port_choice;    // Port code
  logic                   event_output_enable;  // Event routing on
  logic                   core_event_output;    // Event level from core
  logic [REMAP_ONE_W-1:0] remap_one;            // Remap fields
  logic [PIN_TOTAL-1:0]   event_pin_oe;         // Decoded pin drive
  logic [PIN_TOTAL-1:0]   event_pin_level;      // Decoded pin level
  pin_idx_t               signal_pin [SIG_COUNT]; // Pin of each signal

  modport owner (
    output event_pin_number, event_port_choice, event_output_enable,
    output core_event_output, remap_one,
    input  event_pin_oe, event_pin_level, signal_pin
  );
  modport event_side (
    input  event_pin_number, event_port_choice, event_output_enable,
    input  core_event_output,
    output event_pin_oe, event_pin_level
  );
  modport remap_side (
    input  remap_one,
    output signal_pin
  );
endinterface

// >>> verilog/event_pin_router.sv
`timescale 1ns/1ps
module event_pin_router
  import alt_func_pkg::*;
(
  route_cfg_if.event_side cfg
);

  // ----------------------------------------------------------------
  // One decoder per pin
  // ----------------------------------------------------------------
  // Port codes above port E match no pin, so nothing is driven then
  genvar g;
  generate
    for (g = 0; g < PIN_TOTAL; g++) begin : g_pin
      localparam logic [2:0] PORT_CODE = 3'(g / PIN_PER_PORT);
      localparam logic [3:0] PIN_CODE  = 4'(g % PIN_PER_PORT);
      wire hit = (cfg.event_port_choice == PORT_CODE) &&
                 (cfg.event_pin_number == PIN_CODE);
      assign cfg.event_pin_oe[g]    = cfg.event_output_enable && hit;
      assign cfg.event_pin_level[g] = cfg.event_pin_oe[g] && cfg.core_event_output;
    end
  endgenerate

endmodule // event_pin_router

// >>> verilog/remap_pin_decoder.sv
`timescale 1ns/1ps
module remap_pin_decoder
  import alt_func_pkg::*;
(
  route_cfg_if.remap_side cfg
);

  // ----------------------------------------------------------------
  // Field extraction
  // ----------------------------------------------------------------
  wire       spi_one_pin_move    = cfg.remap_one[SPI_MV_BIT];
  wire       i2c_one_pin_move    = cfg.remap_one[I2C_MV_BIT];
  wire       serial_one_pin_move = cfg.remap_one[SER1_MV_BIT];
  wire       serial_two_pin_move = cfg.remap_one[SER2_MV_BIT];
  wire [1:0] serial_three_pin_move = cfg.remap_one[SER3_MV_LSB +: 2];
  wire [1:0] timer_one_pin_move    = cfg.remap_one[TMR1_MV_LSB +: 2];
  wire [1:0] timer_two_pin_move    = cfg.remap_one[TMR2_MV_LSB +: 2];
  wire [1:0] timer_three_pin_move  = cfg.remap_one[TMR3_MV_LSB +: 2];
  wire       timer_four_pin_move   = cfg.remap_one[TMR4_MV_BIT];

  // ----------------------------------------------------------------
  // Pin table; unused codes fall back to the default set
  // ----------------------------------------------------------------
  always_comb begin
    // SPI: nss, sck, miso, mosi
    for (int k = 0; k < 4; k++) begin
      cfg.signal_pin[SIG_SPI+k] = pin_at(PORT_A, 4'(k + 4));
    end
    if (spi_one_pin_move) begin
      cfg.signal_pin[SIG_SPI]   = pin_at(PORT_A, 4'hF);
      for (int k = 1; k < 4; k++) begin
        cfg.signal_pin[SIG_SPI+k] = pin_at(PORT_B, 4'(k + 2));
      end
    end
    // I2C: scl, sda
    for (int k = 0; k < 2; k++) begin
      cfg.signal_pin[SIG_I2C+k] = pin_at(PORT_B,
        i2c_one_pin_move ? 4'(k + 8) : 4'(k + 6));
    end
    // Serial one: tx, rx
    cfg.signal_pin[SIG_SER1]   = serial_one_pin_move ? pin_at(PORT_B, 4'h6)
                                                     : pin_at(PORT_A, 4'h9);
    cfg.signal_pin[SIG_SER1+1] = serial_one_pin_move ? pin_at(PORT_B, 4'h7)
                                                     : pin_at(PORT_A, 4'hA);
    // Serial two: cts, rts, tx, rx, ck
    for (int k = 0; k < 5; k++) begin
      cfg.signal_pin[SIG_SER2+k] = serial_two_pin_move ? pin_at(PORT_D, 4'(k + 3))
                                                       : pin_at(PORT_A, 4'(k));
    end
    // Serial three: tx, rx, ck, cts, rts
    for (int k = 0; k < 5; k++) begin
      cfg.signal_pin[SIG_SER3+k] = pin_at(PORT_B, 4'(k + 10));
      if (serial_three_pin_move == 2'h3) begin
        cfg.signal_pin[SIG_SER3+k] = pin_at(PORT_D, 4'(k + 8));
      end else if (serial_three_pin_move == 2'h1 && k < 3) begin
        cfg.signal_pin[SIG_SER3+k] = pin_at(PORT_C, 4'(k + 10));
      end
    end
    // Timer one: etr, ch1..ch4, break, ch1n..ch3n
    cfg.signal_pin[SIG_TMR1] = pin_at(PORT_A, 4'hC);
    for (int k = 1; k < 5; k++) begin
      cfg.signal_pin[SIG_TMR1+k] = pin_at(PORT_A, 4'(k + 7));
    end
    for (int k = 5; k < 9; k++) begin
      cfg.signal_pin[SIG_TMR1+k] = pin_at(PORT_B, 4'(k + 7));
    end
    if (timer_one_pin_move == 2'h1) begin
      cfg.signal_pin[SIG_TMR1+5] = pin_at(PORT_A, 4'h6);
      cfg.signal_pin[SIG_TMR1+6] = pin_at(PORT_A, 4'h7);
      cfg.signal_pin[SIG_TMR1+7] = pin_at(PORT_B, 4'h0);
      cfg.signal_pin[SIG_TMR1+8] = pin_at(PORT_B, 4'h1);
    end else if (timer_one_pin_move == 2'h3) begin
      cfg.signal_pin[SIG_TMR1]   = pin_at(PORT_E, 4'h7);
      cfg.signal_pin[SIG_TMR1+1] = pin_at(PORT_E, 4'h9);
      cfg.signal_pin[SIG_TMR1+2] = pin_at(PORT_E, 4'hB);
      cfg.signal_pin[SIG_TMR1+3] = pin_at(PORT_E, 4'hD);
      cfg.signal_pin[SIG_TMR1+4] = pin_at(PORT_E, 4'hE);
      cfg.signal_pin[SIG_TMR1+5] = pin_at(PORT_E, 4'hF);
      for (int k = 6; k < 9; k++) begin
        cfg.signal_pin[SIG_TMR1+k] = pin_at(PORT_E, 4'(2 * k - 4));
      end
    end
    // Timer two: ch1/etr, ch2 on low bit; ch3, ch4 on high bit
    cfg.signal_pin[SIG_TMR2]   = timer_two_pin_move[0] ? pin_at(PORT_A, 4'hF)
                                                       : pin_at(PORT_A, 4'h0);
    cfg.signal_pin[SIG_TMR2+1] = timer_two_pin_move[0] ? pin_at(PORT_B, 4'h3)
                                                       : pin_at(PORT_A, 4'h1);
    for (int k = 2; k < 4; k++) begin
      cfg.signal_pin[SIG_TMR2+k] = timer_two_pin_move[1] ? pin_at(PORT_B, 4'(k + 8))
                                                         : pin_at(PORT_A, 4'(k));
    end
    // Timer three: ch1..ch4, etr fixed
    cfg.signal_pin[SIG_TMR3]   = pin_at(PORT_A, 4'h6);
    cfg.signal_pin[SIG_TMR3+1] = pin_at(PORT_A, 4'h7);
    cfg.signal_pin[SIG_TMR3+2] = pin_at(PORT_B, 4'h0);
    cfg.signal_pin[SIG_TMR3+3] = pin_at(PORT_B, 4'h1);
    if (timer_three_pin_move == 2'h2) begin
      cfg.signal_pin[SIG_TMR3]   = pin_at(PORT_B, 4'h4);
      cfg.signal_pin[SIG_TMR3+1] = pin_at(PORT_B, 4'h5);
    end else if (timer_three_pin_move == 2'h3) begin
      for (int k = 0; k < 4; k++) begin
        cfg.signal_pin[SIG_TMR3+k] = pin_at(PORT_C, 4'(k + 6));
      end
    end
    cfg.signal_pin[SIG_TMR3+4] = pin_at(PORT_D, 4'h2);
    // Timer four: ch1..ch4, etr fixed
    for (int k = 0; k < 4; k++) begin
      cfg.signal_pin[SIG_TMR4+k] = timer_four_pin_move ? pin_at(PORT_D, 4'(k + 12))
                                                       : pin_at(PORT_B, 4'(k + 6));
    end
    cfg.signal_pin[SIG_TMR4+4] = pin_at(PORT_E, 4'h0);
  end

endmodule // remap_pin_decoder

// >>> verilog/alternate_function_remap.sv
// What this block does
// - Seven word registers decoded at fixed offsets
// - Pin field picks event pin 0-15
// - Port field picks event port A-E
// - Enable bit routes event; else none
// - Event and remap one reset zero
// - SPI and I2C pin sets move
// - Serial one tx/rx move to port B
// - Serial two lines move to port D
// - Serial three partial/complete moves; 10 ignored
// - Timer one partial/complete moves; 10 ignored
// - Timer two moves each channel pair
// - Timer three sets; 01 ignored; trigger fixed
// - Timer four bit selects alternate set
// - Alternate timer four set PD12-PD15
`timescale 1ns/1ps
module alternate_function_remap
  import alt_func_pkg::*;
(
  input  wire logic                      i_clk,            // Gated peripheral clock
  input  wire logic                      i_arst_n,         // Async reset, active low
  // Peripheral bus slave
  input  wire logic                      i_psel,           // Slave select
  input  wire logic                      i_penable,        // Access phase
  input  wire logic                      i_pwrite,         // Write when high
  input  wire logic [ADDR_W-1:0]         i_paddr,          // Byte address
  input  wire logic [3:0]                i_pstrb,          // Byte strobes
  input  wire logic [DATA_W-1:0]         i_pwdata,         // Write data
  output logic      [DATA_W-1:0]         o_prdata,         // Read data
  output logic                           o_pready,         // Transfer done
  output logic                           o_pslverr,        // Error answer
  // Core event and pin routing
  input  wire logic                      i_core_event_output, // Event from core
  output logic      [PIN_TOTAL-1:0]      o_event_pin_oe,      // Pin takes event
  output logic      [PIN_TOTAL-1:0]      o_event_pin_level,   // Event level on pin
  output logic      [SIG_COUNT*7-1:0]    o_signal_pin_map     // Pin of each signal
);

  // ----------------------------------------------------------------
  // Storage and output flops
  // ----------------------------------------------------------------
  logic [DATA_W-1:0]    regs_ff [REG_COUNT];  // Register file
  logic [DATA_W-1:0]    rdata_ff;             // Read data held for access
  logic                 ready_ff;             // Ready in access phase
  logic                 slverr_ff;            // Error in access phase
  logic [PIN_TOTAL-1:0] event_oe_ff;          // Registered pin drive
  logic [PIN_TOTAL-1:0] event_level_ff;       // Registered pin level
  logic [SIG_COUNT*7-1:0] pin_map_ff;         // Registered pin map

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // Word index comes straight from the byte address
  wire [IDX_W-1:0] reg_idx     = i_paddr[IDX_W+1:2];
  // Upper address bits must be clear for a hit
  wire             upper_clear = (i_paddr[ADDR_W-1:IDX_W+2] == '0);
  // Only aligned words land on a register
  wire             aligned     = (i_paddr[1:0] == WORD_ALIGN);
  // Index beyond the last register is unmapped
  wire             idx_in_map  = (reg_idx < IDX_W'(REG_COUNT));
  wire             addr_hit    = upper_clear && aligned && idx_in_map;
  // Partial strobes on writes are refused; nothing is written then
  wire             full_word   = (i_pstrb == FULL_STROBE);

  // ----------------------------------------------------------------
  // Phase decode
  // ----------------------------------------------------------------
  // Setup phase: answer is prepared here for zero wait states
  wire setup_phase  = i_psel && !i_penable;
  // Access phase: writes commit here
  wire access_phase = i_psel && i_penable;
  // Legal write: mapped, aligned, full strobes
  wire write_ok     = access_phase && i_pwrite && addr_hit && full_word;
  // Error for any unmapped access or partial write
  wire access_bad   = !addr_hit || (i_pwrite && !full_word);

  // ----------------------------------------------------------------
  // Read selection
  // ----------------------------------------------------------------
  // Unmapped reads return zero alongside the error answer
  wire [DATA_W-1:0] read_word  = addr_hit ? regs_ff[reg_idx] : RESET_VALUE;
  // Reserved bits always read zero
  wire [DATA_W-1:0] read_value = read_word & reg_mask(reg_idx);
  // Strobes are ignored on reads, as the bus allows
  wire [DATA_W-1:0] nxt_rdata  = (setup_phase && !i_pwrite) ? read_value : RESET_VALUE;

  // ----------------------------------------------------------------
  // Register file, one entry per word
  // ----------------------------------------------------------------
  // Stored value is already masked, so reserved bits stay zero even
  // though the config outputs read the whole word
  genvar g;
  generate
    for (g = 0; g < REG_COUNT; g++) begin : g_reg
      localparam logic [IDX_W-1:0] MY_IDX = IDX_W'(g);
      wire hit_me = write_ok && (reg_idx == MY_IDX);
      // Entry update
      always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
          regs_ff[g] <= RESET_VALUE;
        end else if (hit_me) begin
          regs_ff[g] <= i_pwdata & reg_mask(MY_IDX);
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Bus answer
  // ----------------------------------------------------------------
  // Ready rises for the access phase only; one transfer per two cycles
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ready_ff  <= 1'b0;
      slverr_ff <= 1'b0;
      rdata_ff  <= RESET_VALUE;
    end else begin
      ready_ff  <= setup_phase;
      slverr_ff <= setup_phase && access_bad;
      rdata_ff  <= nxt_rdata;
    end
  end

  assign o_prdata  = rdata_ff;
  assign o_pready  = ready_ff;
  assign o_pslverr = slverr_ff;

  // ----------------------------------------------------------------
  // Configuration to the decoders
  // ----------------------------------------------------------------
  // The register clock is gated upstream; writes made before the clock
  // is enabled are simply never seen
  route_cfg_if cfg ();

  wire [DATA_W-1:0] ev_word = regs_ff[IDX_EVENT_ROUTE];
  assign cfg.event_pin_number    = ev_word[EV_PIN_LSB +: 4];
  assign cfg.event_port_choice   = ev_word[EV_PORT_LSB +: 3];
  assign cfg.event_output_enable = ev_word[EV_EN_BIT];
  // Event comes from same-clock core logic, no synchroniser needed
  assign cfg.core_event_output   = i_core_event_output;
  assign cfg.remap_one = regs_ff[IDX_REMAP_ONE][REMAP_ONE_W-1:0];

  // Event pin decode
  event_pin_router u_event_router (
    .cfg (cfg.event_side)
  );

  // Remap pin decode
  remap_pin_decoder u_remap_decoder (
    .cfg (cfg.remap_side)
  );

  // ----------------------------------------------------------------
  // Pin map flattening
  // ----------------------------------------------------------------
  // Slot k sits at bits 7k+6..7k of the flat map
  logic [SIG_COUNT*7-1:0] nxt_pin_map;
  generate
    for (g = 0; g < SIG_COUNT; g++) begin : g_map
      assign nxt_pin_map[g*7 +: 7] = cfg.signal_pin[g];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------
  // One cycle of latency on the event traded for glitch-free outputs
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      event_oe_ff    <= '0;
      event_level_ff <= '0;
    end else begin
      event_oe_ff    <= cfg.event_pin_oe;
      event_level_ff <= cfg.event_pin_level;
    end
  end

  // Pin map reset loads zero into every slot, not the default sets
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pin_map_ff <= '0;
    end else begin
      pin_map_ff <= nxt_pin_map;
    end
  end

  assign o_event_pin_oe    = event_oe_ff;
  assign o_event_pin_level = event_level_ff;
  assign o_signal_pin_map  = pin_map_ff;

endmodule // alternate_function_remap

// >>> sim/afr_checker_assertions.sv
`timescale 1ns/1ps
module afr_checker
  import alt_func_pkg::*;
(
  input wire logic                   i_clk,
  input wire logic                   i_arst_n,
  input wire logic                   i_psel,
  input wire logic                   i_penable,
  input wire logic                   i_pwrite,
  input wire logic [ADDR_W-1:0]      i_paddr,
  input wire logic [3:0]             i_pstrb,
  input wire logic [DATA_W-1:0]      i_pwdata,
  input wire logic [DATA_W-1:0]      o_prdata,
  input wire logic                   o_pready,
  input wire logic                   o_pslverr,
  input wire logic                   i_core_event_output,
  input wire logic [PIN_TOTAL-1:0]   o_event_pin_oe,
  input wire logic [PIN_TOTAL-1:0]   o_event_pin_level,
  input wire logic [SIG_COUNT*7-1:0] o_signal_pin_map
);
  // ----------------------------------------------------------------
  // One clock domain, reset disables everything
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  a_answer_next_cycle: assert property (i_psel && !i_penable |=> o_pready)
    else $error("no answer in access phase");
  a_answer_single: assert property (o_pready |=> !o_pready)
    else $error("answer stood longer than one cycle");
  a_unmapped_refused: assert property (i_psel && !i_penable && i_paddr > OFS_REMAP_TWO
    |=> o_pslverr && o_prdata == 32'h0) else $error("unmapped access not refused");
  a_partial_refused: assert property (i_psel && !i_penable && i_pwrite
    && i_pstrb != FULL_STROBE |=> o_pslverr) else $error("partial write not refused");
  a_route_upper_zero: assert property (o_pready && !i_pwrite && i_paddr == OFS_EVENT_ROUTE
    |-> o_prdata[31:8] == 24'h0) else $error("event route upper bits not zero");
  a_one_event_pin: assert property ($onehot0(o_event_pin_oe))
    else $error("event driven on more than one pin");
  a_level_gated: assert property (o_event_pin_level ==
    (o_event_pin_oe & {PIN_TOTAL{$past(i_core_event_output)}})) else $error("event level wrong");
  a_trigger_fixed: assert property ($past(i_arst_n) |-> o_signal_pin_map[245 +: 7]
    == 7'h32 && o_signal_pin_map[280 +: 7] == 7'h40) else $error("timer trigger pin moved");
endmodule // afr_checker

bind alternate_function_remap afr_checker i_chk (.i_clk(i_clk), .i_arst_n(i_arst_n),
  .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
  .i_pstrb(i_pstrb), .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
  .o_pslverr(o_pslverr), .i_core_event_output(i_core_event_output),
  .o_event_pin_oe(o_event_pin_oe), .o_event_pin_level(o_event_pin_level),
  .o_signal_pin_map(o_signal_pin_map));

// >>> sim/tb.sv
`timescale 1ns/1ps
module tb;
  import alt_func_pkg::*;
  logic                   i_clk, i_arst_n, i_psel, i_penable, i_pwrite;  // Bus controls
  logic                   i_core_event_output, o_pready, o_pslverr;      // Event, answer
  logic [ADDR_W-1:0]      i_paddr;                                       // Byte address
  logic [3:0]             i_pstrb;                                       // Byte strobes
  logic [DATA_W-1:0]      i_pwdata, o_prdata;                            // Data both ways
  logic [PIN_TOTAL-1:0]   o_event_pin_oe, o_event_pin_level;             // Event pins
  logic [SIG_COUNT*7-1:0] o_signal_pin_map;                              // Pin of each signal
  int                     failures, check_count;                         // Tallies

  alternate_function_remap i_dut (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pstrb(i_pstrb),
    .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .i_core_event_output(i_core_event_output), .o_event_pin_oe(o_event_pin_oe),
    .o_event_pin_level(o_event_pin_level), .o_signal_pin_map(o_signal_pin_map));

  // 250 MHz clock
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end

  // ----------------------------------------------------------------
  // Compare tasks, one per kind of result
  // ----------------------------------------------------------------
  task automatic check_word(string name, logic [DATA_W-1:0] exp, logic [DATA_W-1:0] got);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic check_pin(string name, logic [6:0] exp, logic [6:0] got);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic check_pins(string name, logic [PIN_TOTAL-1:0] exp, logic [PIN_TOTAL-1:0] got);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  // ----------------------------------------------------------------
  // Bus transfer: setup, then access with zero wait states
  // ----------------------------------------------------------------
  task automatic access(logic wr, logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d,
                        logic [3:0] s, logic exp_err, logic [DATA_W-1:0] exp_rd);
    @(negedge i_clk);
    i_psel = 1'b1;
    i_penable = 1'b0;
    i_pwrite = wr;
    i_paddr = a;
    i_pstrb = s;
    i_pwdata = d;
    @(negedge i_clk);
    i_penable = 1'b1;
    // Answer already stands since the setup edge; the closing edge takes it
    check_word("answer", {30'h0, 1'b1, exp_err}, {30'h0, o_pready, o_pslverr});
    if (!wr) check_word("prdata", exp_rd, o_prdata);
    @(negedge i_clk);
    i_psel = 1'b0;
    i_penable = 1'b0;
  endtask

  // Write remap one, let the map flop settle, look at two slots
  task automatic remap_case(logic [DATA_W-1:0] v, int s1, logic [6:0] p1, int s2,
                            logic [6:0] p2);
    access(1'b1, OFS_REMAP_ONE, v, FULL_STROBE, 1'b0, 32'h0);
    repeat (2) @(negedge i_clk);
    check_pin($sformatf("slot%0d", s1), p1, o_signal_pin_map[s1*7 +: 7]);
    check_pin($sformatf("slot%0d", s2), p2, o_signal_pin_map[s2*7 +: 7]);
  endtask

  // Route the event; a negative bit number means no pin may carry it
  task automatic event_case(logic [7:0] v, logic ev, int bit_no);
    logic [PIN_TOTAL-1:0] exp;
    i_core_event_output = ev;
    access(1'b1, OFS_EVENT_ROUTE, {24'h0, v}, FULL_STROBE, 1'b0, 32'h0);
    repeat (2) @(negedge i_clk);
    exp = (bit_no < 0) ? '0 : ({{(PIN_TOTAL-1){1'b0}}, 1'b1} << bit_no);
    check_pins("event_oe", exp, o_event_pin_oe);
    check_pins("event_level", ev ? exp : '0, o_event_pin_level);
  endtask

  task automatic stop_test();
    $display("Checks made %0d, mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #200000;
    failures++;
    stop_test();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {i_arst_n, i_psel, i_penable, i_pwrite, i_core_event_output} = 5'h00;
    i_paddr = 8'h00;
    i_pstrb = 4'h0;
    i_pwdata = 32'h0;
    failures = 0;
    check_count = 0;
    repeat (20) @(negedge i_clk);
    i_arst_n = 1'b1;
    for (int i = 0; i < REG_COUNT; i++)
      access(1'b0, 8'(i*4), 32'h0, FULL_STROBE, 1'b0, 32'h0);
    check_pins("reset_oe", '0, o_event_pin_oe);
    access(1'b1, OFS_EVENT_ROUTE, 32'hFFFF_FFFF, FULL_STROBE, 1'b0, 32'h0);
    access(1'b0, OFS_EVENT_ROUTE, 32'h0, FULL_STROBE, 1'b0, 32'h0000_00FF);
    access(1'b1, OFS_REMAP_ONE, 32'hFFFF_FFFF, FULL_STROBE, 1'b0, 32'h0);
    access(1'b0, OFS_REMAP_ONE, 32'h0, FULL_STROBE, 1'b0, 32'h0000_1FFF);
    for (int i = 2; i < REG_COUNT; i++) begin
      access(1'b1, 8'(i*4), 32'hA5C3_0F00 | i, FULL_STROBE, 1'b0, 32'h0);
      access(1'b0, 8'(i*4), 32'h0, FULL_STROBE, 1'b0, 32'hA5C3_0F00 | i);
    end
    access(1'b1, 8'h1C, 32'h1234_5678, FULL_STROBE, 1'b1, 32'h0);
    access(1'b0, 8'h1C, 32'h0, FULL_STROBE, 1'b1, 32'h0);
    access(1'b0, 8'h05, 32'h0, FULL_STROBE, 1'b1, 32'h0);
    access(1'b1, OFS_REMAP_ONE, 32'h0, 4'h3, 1'b1, 32'h0);
    access(1'b0, OFS_REMAP_ONE, 32'h0, FULL_STROBE, 1'b0, 32'h0000_1FFF);
    event_case(8'hB5, 1'b1, 53);
    event_case(8'hCF, 1'b1, 79);
    event_case(8'h80, 1'b0, 0);
    event_case(8'h4F, 1'b1, -1);
    event_case(8'hD0, 1'b1, -1);
    remap_case(32'h0, 0, 7'h04, 4, 7'h16);
    remap_case(32'h0, 6, 7'h09, 8, 7'h00);
    remap_case(32'h0, 13, 7'h1A, 18, 7'h0C);
    remap_case(32'h0, 23, 7'h1C, 27, 7'h00);
    remap_case(32'h0, 31, 7'h06, 36, 7'h16);
    remap_case(32'h1FFF, 0, 7'h0F, 5, 7'h19);
    remap_case(32'h1FFF, 7, 7'h17, 12, 7'h37);
    remap_case(32'h1FFF, 13, 7'h38, 23, 7'h4F);
    remap_case(32'h1FFF, 29, 7'h1A, 31, 7'h26);
    remap_case(32'h1FFF, 36, 7'h3C, 39, 7'h3F);
    remap_case(32'h0010, 13, 7'h2A, 16, 7'h1D);
    remap_case(32'h0020, 13, 7'h1A, 17, 7'h1E);
    remap_case(32'h0040, 23, 7'h06, 24, 7'h07);
    remap_case(32'h0080, 23, 7'h1C, 18, 7'h0C);
    remap_case(32'h0100, 27, 7'h0F, 29, 7'h02);
    remap_case(32'h0200, 27, 7'h00, 29, 7'h1A);
    remap_case(32'h0400, 31, 7'h06, 35, 7'h32);
    remap_case(32'h0800, 31, 7'h14, 33, 7'h10);
    stop_test();
  end
endmodule // tb
